//--- bench/pad_env_model.sv
/* pad environment and pin-change consumer seen from the port pins.
   assumes pad controls from the port block; floating pins wobble. */
module pad_env_model (
   // clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // pad controls and external drive
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // consumer side
   input wire logic [7:0] alt_func_raw_input,
   output logic     [7:0] pad_in,
   output logic     [7:0] sync_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] float_q, sync_q;
   // floating pins flip so no stale level passes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         float_q <= 8'h55;
         sync_q  <= 8'h00;
         sync_in <= 8'h00;
      end else begin
         float_q <= ~float_q;
         sync_q  <= alt_func_raw_input;
         sync_in <= sync_q;
      end
   end
   // own drive, then outside source, then pull-up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pullup_en | float_q));
endmodule : pad_env_model

//--- bench/port_mux_props.sv
/* checker for the port A pin override block, watching only its ports.
   assumes hready is tied to hreadyout and transfers are whole words. */
module port_mux_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // pads
   input wire logic [7:0]  pad_in,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pad_pullup_en,
   input wire logic [7:0]  pad_digital_in_en,
   input wire logic [7:0]  alt_func_raw_input,
   input wire logic [7:0]  pad_analog_line
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // data phase trackers
   // ------------------------------------------------------------
   wire logic taken  = hsel & hready & htrans[1];
   wire logic dir_hit = taken & hwrite & (haddr[7:0] == port_mux_pkg::OFFS_DIRECTION);
   wire logic lat_hit = taken & hwrite & (haddr[7:0] == port_mux_pkg::OFFS_OUT_LATCH);
   wire logic st_hit  = taken & ~hwrite & (haddr[7:0] == port_mux_pkg::OFFS_PAD_STATUS);
   logic       dir_wr_q, lat_wr_q, st_rd_q;
   // data phase flags, one edge after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_wr_q <= 1'b0;
         lat_wr_q <= 1'b0;
         st_rd_q  <= 1'b0;
      end else begin
         dir_wr_q <= dir_hit;
         lat_wr_q <= lat_hit;
         st_rd_q  <= st_hit;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   ready_okay_a: assert property (
      hreadyout && (hresp == port_mux_pkg::RESP_OKAY)) else $error("bus not okay");
   out_gated_a: assert property (
      (pad_out & ~pad_oe) == 8'h00) else $error("level on undriven pin");
   raw_input_a: assert property (
      alt_func_raw_input == (pad_in & pad_digital_in_en)) else $error("raw input wrong");
   analog_line_a: assert property (
      pad_analog_line == pad_in) else $error("analog line not pad");
   pullup_drive_a: assert property (
      (pad_pullup_en & pad_oe) == 8'h00) else $error("pull-up on driven pin");
   dir_write_a: assert property (
      dir_wr_q |-> ##2 (32'(pad_oe) == ($past(hwdata, 2) & 32'hFF)))
      else $error("oe not from direction");
   latch_write_a: assert property (
      lat_wr_q |-> ##2 (32'(pad_out) == ($past(hwdata, 2) & 32'(pad_oe))))
      else $error("level not from latch");
   status_read_a: assert property (
      st_rd_q |-> hrdata == {8'h00, $past(pad_digital_in_en), $past(pad_pullup_en),
                             $past(pad_oe)}) else $error("status read wrong");
endmodule : port_mux_props

//--- bench/port_pin_override_mux_bench.sv
/* self-checking bench for the port A pin override block.
   assumes a zero wait state slave and the pad model beside it. */
module port_pin_override_mux_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep_clamp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup_en, pad_digital_in_en;
   logic [7:0]  alt_func_raw_input, pad_analog_line, ext_en, ext_val, sync_in;
   int          error_cnt = 0, check_count = 0;
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   port_pin_override_mux DUT (.*);
   pad_env_model env (.*);
   // ------------------------------------------------------------
   // bus and check helpers
   // ------------------------------------------------------------
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // bounded wait for an edge with hready high
   task automatic wait_ready;
      int n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         if (n >= 100) begin
            error_cnt++;
            print_verdict();
         end
         n++;
         @(posedge hclk);
      end
   endtask : wait_ready
   task xfer(input logic wr, input logic [7:0] o, input logic [31:0] wd,
             output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= port_mux_pkg::HTRANS_NSEQ;
      haddr  <= {24'h0, o};
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
   // pads follow one edge after the register takes the word
   task wr(input logic [7:0] o, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, o, {24'h0, d}, x);
      @(posedge hclk);
      #1;
   endtask : wr
   task rd(input string nm, input logic [7:0] o, input logic [31:0] exp);
      logic [31:0] x;
      xfer(1'b0, o, 32'h0, x);
      check(nm, exp, x);
   endtask : rd
   task set_sleep(input logic s);
      @(posedge hclk);
      sleep_clamp <= s;
      @(posedge hclk);
      #1;
   endtask : set_sleep
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      check("pads idle", 32'h0, {8'h00, pad_out, pad_oe, pad_pullup_en});
      check("input enable", 32'hFF, 32'(pad_digital_in_en));
      rd("status", port_mux_pkg::OFFS_PAD_STATUS, 32'h00FF_0000);
      wr(8'h1C, 8'hFF);
      rd("unmapped", 8'h1C, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_drive;
      wr(port_mux_pkg::OFFS_DIRECTION, 8'hA5);
      wr(port_mux_pkg::OFFS_OUT_LATCH, 8'h3C);
      check("driver enable", 32'hA5, 32'(pad_oe));
      check("driven level", 32'h24, 32'(pad_out));
      check("pad level", 32'h24, 32'(pad_in & pad_oe));
      check("pull-up", 32'h18, 32'(pad_pullup_en));
      rd("direction", port_mux_pkg::OFFS_DIRECTION, 32'hA5);
      $display("test drive done");
   endtask : t_drive
   task t_pullup;
      logic [7:0] tab [4][4];
      tab = '{'{8'h00, 8'hFF, 8'h00, 8'hFF}, '{8'h0F, 8'h33, 8'h00, 8'h30},
              '{8'h00, 8'hFF, 8'h01, 8'h00}, '{8'hFF, 8'hFF, 8'h00, 8'h00}};
      // direction, latch, global pull-up off, expected pull-ups
      for (int i = 0; i < 4; i++) begin
         wr(port_mux_pkg::OFFS_DIRECTION, tab[i][0]);
         wr(port_mux_pkg::OFFS_OUT_LATCH, tab[i][1]);
         wr(port_mux_pkg::OFFS_CONTROL, tab[i][2]);
         check("pull-up", 32'(tab[i][3]), 32'(pad_pullup_en));
         check("no dir override", 32'(tab[i][0]), 32'(pad_oe));
      end
      wr(port_mux_pkg::OFFS_CONTROL, 8'h00);
      $display("test pull-up done");
   endtask : t_pullup
   task t_toggle;
      wr(port_mux_pkg::OFFS_DIRECTION, 8'hFF);
      wr(port_mux_pkg::OFFS_OUT_LATCH, 8'h3C);
      wr(port_mux_pkg::OFFS_IN_SAMPLE, 8'h0F);
      check("toggled level", 32'h33, 32'(pad_out));
      wr(port_mux_pkg::OFFS_DIRECTION, 8'h00);
      wr(port_mux_pkg::OFFS_IN_SAMPLE, 8'hF0);
      rd("toggled latch", port_mux_pkg::OFFS_OUT_LATCH, 32'hC3);
      $display("test toggle done");
   endtask : t_toggle
   task t_input;
      @(posedge hclk);
      ext_en  <= 8'hFF;
      ext_val <= 8'h96;
      repeat (4) @(posedge hclk);
      #1;
      check("raw input", 32'h96, 32'(alt_func_raw_input));
      check("analog line", 32'h96, 32'(pad_analog_line));
      check("consumer sync", 32'h96, 32'(sync_in));
      rd("sample", port_mux_pkg::OFFS_IN_SAMPLE, 32'h96);
      set_sleep(1'b1);
      check("sleep clamp", 32'h0, 32'(pad_digital_in_en));
      wr(port_mux_pkg::OFFS_CONTROL, 8'h02);
      for (int n = 0; n < 8; n++) begin
         wr(port_mux_pkg::OFFS_PCHG_SRC, 8'h01 << n);
         check("pin change enable", 32'h1 << n, 32'(pad_digital_in_en));
      end
      wr(port_mux_pkg::OFFS_PCHG_SRC, 8'h00);
      set_sleep(1'b0);
      wr(port_mux_pkg::OFFS_DIGIN_OFF, 8'h02);
      check("digital off", 32'hFD, 32'(pad_digital_in_en));
      wr(port_mux_pkg::OFFS_PCHG_SRC, 8'h02);
      check("override value", 32'hFF, 32'(pad_digital_in_en));
      $display("test input done");
   endtask : t_input
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      sleep_clamp = 1'b0;
      ext_en = 8'h00;
      ext_val = 8'h00;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      #1;
      t_reset();
      t_drive();
      t_pullup();
      t_toggle();
      t_input();
      print_verdict();
   end
endmodule : port_pin_override_mux_bench
bind port_pin_override_mux port_mux_props chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pad_in, .pad_out, .pad_oe,
   .pad_pullup_en, .pad_digital_in_en, .alt_func_raw_input, .pad_analog_line);

//--- shared/pin_override_if.sv
/*
 * holds the per-pin override bundle passed from the alternate function
 * owners to the override cell.
 * assumes one bit per pin, all on the I/O clock.
 */
interface pin_override_if;
   logic [7:0] pullup_override_en;
   logic [7:0] pullup_override_val;
   logic [7:0] dir_override_en;
   logic [7:0] dir_override_val;
   logic [7:0] outval_override_en;
   logic [7:0] outval_override_val;
   logic [7:0] latch_toggle_override_en;
   logic [7:0] input_en_override_en;
   logic [7:0] input_en_override_val;

   // alternate function owner drives every pair
   modport source (
      output pullup_override_en, pullup_override_val, dir_override_en,
             dir_override_val, outval_override_en, outval_override_val,
             latch_toggle_override_en, input_en_override_en,
             input_en_override_val
   );
   // override cell only reads them
   modport sink (
      input  pullup_override_en, pullup_override_val, dir_override_en,
             dir_override_val, outval_override_en, outval_override_val,
             latch_toggle_override_en, input_en_override_en,
             input_en_override_val
   );
endinterface : pin_override_if

//--- shared/port_mux_pkg.sv
/*
 * holds the register map, field positions, reset values and widths of the
 * port pin override block.
 * assumes a 32-bit AHB-Lite slave, one aligned word per register.
 */
package port_mux_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int unsigned PIN_COUNT  = 8;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned ADDR_W     = 32;
   localparam int unsigned OFFS_W     = 8;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFFS_DIRECTION   = 8'h00;  // pin_direction_bit per pin
   localparam logic [7:0] OFFS_OUT_LATCH   = 8'h04;  // pin_output_latch_bit per pin
   localparam logic [7:0] OFFS_IN_SAMPLE   = 8'h08;  // read sample, write one toggles
   localparam logic [7:0] OFFS_CONTROL     = 8'h0C;  // global bits
   localparam logic [7:0] OFFS_PCHG_SRC    = 8'h10;  // pin_change_irq_src mask
   localparam logic [7:0] OFFS_DIGIN_OFF   = 8'h14;  // analog_ch_digin_off per pin
   localparam logic [7:0] OFFS_PAD_STATUS  = 8'h18;  // live pad drive view

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_PULLUP_OFF_BIT = 0;
   localparam int unsigned CTRL_GROUP0_EN_BIT  = 1;
   localparam int unsigned CTRL_W              = 2;

   // status register fields: byte lanes of the pad view
   localparam int unsigned STAT_OE_LSB     = 0;
   localparam int unsigned STAT_PULLUP_LSB = 8;
   localparam int unsigned STAT_DIN_EN_LSB = 16;

   // ---------------------------------------------------------------
   // reset values and constants
   // ---------------------------------------------------------------
   localparam logic [7:0]        PIN_RESET   = 8'h00;
   localparam logic [1:0]        CTRL_RESET  = 2'h0;
   localparam logic [31:0]       WORD_ZERO   = 32'h0000_0000;
   localparam logic [7:0]        OVR_TIE_OFF = 8'h00;  // unused override enables
   localparam logic              RESP_OKAY   = 1'b0;
   localparam logic [1:0]        HTRANS_NSEQ = 2'h2;

endpackage : port_mux_pkg

//--- verilog/pin_override_cell.sv
/*
 * holds the combinational override selection for every pin of one port.
 * assumes register bits and overrides come from logic on the same clock.
 */
module pin_override_cell (
   // override bundle
   pin_override_if.sink    ovr,
   // port register bits
   input  wire logic [7:0] pin_direction_bit,
   input  wire logic [7:0] pin_output_latch_bit,
   // bits common to all ports
   input  wire logic       global_pullup_off,
   input  wire logic       sleep_clamp,
   // resolved pad controls
   output logic [7:0]      pull_up_on,
   output logic [7:0]      drive_en,
   output logic [7:0]      drive_val,
   output logic [7:0]      digital_in_en,
   output logic [7:0]      latch_toggle
);

   // ---------------------------------------------------------------
   // per-pin selection
   // ---------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < port_mux_pkg::PIN_COUNT; n++) begin : g_pin
         wire logic plain_pullup;
         wire logic plain_din_en;

         // pull-up only for input, latch one, global disable clear
         assign plain_pullup = ({pin_direction_bit[n], pin_output_latch_bit[n],
                                 global_pullup_off} == 3'b010);  // R01
         assign pull_up_on[n] = ovr.pullup_override_en[n] ?
                                ovr.pullup_override_val[n] : plain_pullup;  // R02

         // direction bit set means output driver on
         assign drive_en[n] = ovr.dir_override_en[n] ?
                              ovr.dir_override_val[n] : pin_direction_bit[n];  // R03 R04 R17

         // value only reaches the pad while the driver is on
         assign drive_val[n] = ovr.outval_override_en[n] ?
                               ovr.outval_override_val[n] : pin_output_latch_bit[n];  // R05 R06

         // sleep clamps the input unless an owner overrides it
         assign plain_din_en     = ~sleep_clamp;
         assign digital_in_en[n] = ovr.input_en_override_en[n] ?
                                   ovr.input_en_override_val[n] : plain_din_en;  // R08 R09

         assign latch_toggle[n] = ovr.latch_toggle_override_en[n];  // R07
      end
   endgenerate

endmodule : pin_override_cell

//--- verilog/port_pin_override_mux.sv
/*
 * holds the port A pin logic: direction, output latch and input sample
 * registers on AHB-Lite, the pin-change and analog-channel owners' override
 * terms, and the pad controls.
 * assumes one clock, pad levels arriving asynchronously, a pull-up and
 * driver outside that act on the pad control outputs.
 */
// Our own choices: the register addresses and the AHB-Lite interface to the registers.

// Notes on behaviour
// R01: no override: pull-up when dir,latch,off = 010
// R02: pull-up override enable: pull-up follows value
// R03: driver from direction bit unless overridden
// R04: direction override value switches driver directly
// R05: driven level from value override or latch
// R06: value override wins over latch contents
// R07: toggle override enable inverts the latch
// R08: input enable follows sleep unless overridden
// R09: input enable override value decides input
// R10: raw input after input gate, before synchroniser
// R11: consumers synchronise raw input themselves
// R12: analog line wired straight to pad
// R13: strobes per port, globals shared, overrides per pin
// R14: overrides made by owning peripheral logic
// R15: pin n: analog channel n, pin-change n
// R16: port A: only input-enable override used
// R17: direction one is output, zero input
// R18: writing one to sample bit toggles latch
// R19: unused override enables tied inactive
module port_pin_override_mux (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // controller state, common to all ports
   input  wire logic        sleep_clamp,
   // pads
   input  wire logic [7:0]  pad_in,
   output logic      [7:0]  pad_out,
   output logic      [7:0]  pad_oe,
   output logic      [7:0]  pad_pullup_en,
   output logic      [7:0]  pad_digital_in_en,
   // alternate function views
   output logic      [7:0]  alt_func_raw_input,
   output logic      [7:0]  pad_analog_line
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [7:0]  dir_reg,      dir_next;
   logic [7:0]  latch_reg,    latch_next;
   logic [1:0]  ctrl_reg,     ctrl_next;
   logic [7:0]  pchg_reg,     pchg_next;
   logic [7:0]  digoff_reg,   digoff_next;
   logic [7:0]  sync1_reg;
   logic [7:0]  sync2_reg;
   logic [7:0]  sample_reg;
   logic [7:0]  out_reg,      oe_reg;
   logic [7:0]  pull_reg,     din_en_reg;
   logic [31:0] rdata_reg,    rdata_next;
   logic        wr_pend_reg;
   logic [7:0]  wr_offs_reg;

   wire logic       addr_phase;
   wire logic       wr_dir;
   wire logic       wr_latch;
   wire logic       wr_sample;
   wire logic       wr_ctrl;
   wire logic       wr_pchg;
   wire logic       wr_digoff;
   wire logic [7:0] wbyte;
   wire logic [7:0] toggle_mask;
   wire logic [7:0] pchg_active;
   wire logic [7:0] pull_now, oe_now, val_now, din_now, ovr_toggle;
   wire logic [7:0] rd_offs;
   wire logic       global_pullup_off;
   wire logic       pin_change_group0_en;

   pin_override_if ovr_bus ();

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   // nonseq or seq on a ready cycle; no wait states are ever added
   assign addr_phase = hsel & hready & htrans[1];
   assign rd_offs    = haddr[port_mux_pkg::OFFS_W-1:0];
   assign wbyte      = hwdata[7:0];

   // one strobe per register, shared by all eight pins
   assign wr_dir    = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_DIRECTION);   // R13
   assign wr_latch  = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_OUT_LATCH);   // R13
   assign wr_sample = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_IN_SAMPLE);   // R13
   assign wr_ctrl   = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_CONTROL);
   assign wr_pchg   = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_PCHG_SRC);
   assign wr_digoff = wr_pend_reg & (wr_offs_reg == port_mux_pkg::OFFS_DIGIN_OFF);

   // write phase is one cycle after the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_offs_reg <= port_mux_pkg::PIN_RESET;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         wr_offs_reg <= rd_offs;
      end
   end

   // ---------------------------------------------------------------
   // global control bits
   // ---------------------------------------------------------------
   assign global_pullup_off    = ctrl_reg[port_mux_pkg::CTRL_PULLUP_OFF_BIT];  // R13
   assign pin_change_group0_en = ctrl_reg[port_mux_pkg::CTRL_GROUP0_EN_BIT];

   // ---------------------------------------------------------------
   // register next values
   // ---------------------------------------------------------------
   // a word store and a toggle in one cycle: store first, toggle on top
   assign toggle_mask = (wr_sample ? wbyte : port_mux_pkg::PIN_RESET)
                        | ovr_toggle;                               // R18 R07

   assign dir_next    = wr_dir    ? wbyte : dir_reg;
   assign latch_next  = (wr_latch ? wbyte : latch_reg) ^ toggle_mask;  // R18 R07
   assign ctrl_next   = wr_ctrl   ? hwdata[port_mux_pkg::CTRL_W-1:0] : ctrl_reg;
   assign pchg_next   = wr_pchg   ? wbyte : pchg_reg;
   assign digoff_next = wr_digoff ? wbyte : digoff_reg;

   // software-visible port registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_reg    <= port_mux_pkg::PIN_RESET;
         latch_reg  <= port_mux_pkg::PIN_RESET;
         ctrl_reg   <= port_mux_pkg::CTRL_RESET;
         pchg_reg   <= port_mux_pkg::PIN_RESET;
         digoff_reg <= port_mux_pkg::PIN_RESET;
      end else begin
         dir_reg    <= dir_next;
         latch_reg  <= latch_next;
         ctrl_reg   <= ctrl_next;
         pchg_reg   <= pchg_next;
         digoff_reg <= digoff_next;
      end
   end

   // ---------------------------------------------------------------
   // port a alternate function owners
   // ---------------------------------------------------------------
   // pin n carries pin-change source n and analog channel n
   assign pchg_active = pchg_reg & {port_mux_pkg::PIN_COUNT{pin_change_group0_en}};  // R15

   // these terms stand for the pin-change and converter logic that owns them
   assign ovr_bus.pullup_override_en       = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.pullup_override_val      = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.dir_override_en          = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.dir_override_val         = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.outval_override_en       = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.outval_override_val      = port_mux_pkg::OVR_TIE_OFF;  // R16 R19
   assign ovr_bus.latch_toggle_override_en = port_mux_pkg::OVR_TIE_OFF;  // R19
   assign ovr_bus.input_en_override_en     = pchg_active | digoff_reg;   // R16 R14
   assign ovr_bus.input_en_override_val    = pchg_active;                // R16 R14

   // ---------------------------------------------------------------
   // override selection
   // ---------------------------------------------------------------
   pin_override_cell u_cell (
      .ovr                  (ovr_bus),
      .pin_direction_bit    (dir_reg),
      .pin_output_latch_bit (latch_reg),
      .global_pullup_off    (global_pullup_off),
      .sleep_clamp          (sleep_clamp),
      .pull_up_on           (pull_now),
      .drive_en             (oe_now),
      .drive_val            (val_now),
      .digital_in_en        (din_now),
      .latch_toggle         (ovr_toggle)
   );

   // pad controls registered so no glitch from decode reaches the pad
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe_reg     <= port_mux_pkg::PIN_RESET;  // tri-stated in reset
         out_reg    <= port_mux_pkg::PIN_RESET;
         pull_reg   <= port_mux_pkg::PIN_RESET;
         din_en_reg <= port_mux_pkg::PIN_RESET;
      end else begin
         oe_reg     <= oe_now;                   // R03 R04 R17
         out_reg    <= val_now & oe_now;         // R05
         pull_reg   <= pull_now;                 // R01 R02
         din_en_reg <= din_now;                  // R08 R09
      end
   end

   // ---------------------------------------------------------------
   // input path
   // ---------------------------------------------------------------
   // raw gated level for owners; they add their own synchroniser
   assign alt_func_raw_input = pad_in & din_en_reg;  // R10 R11

   // analog owners see the pad itself, no gate in the way
   assign pad_analog_line = pad_in;  // R12

   // two-stage synchroniser, then the software sample register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg  <= port_mux_pkg::PIN_RESET;
         sync2_reg  <= port_mux_pkg::PIN_RESET;
         sample_reg <= port_mux_pkg::PIN_RESET;
      end else begin
         sync1_reg  <= pad_in;
         sync2_reg  <= sync1_reg;
         sample_reg <= sync2_reg & din_en_reg;   // R10
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   // read mux works on next values so a read right behind a write sees it
   always_comb begin
      rdata_next = port_mux_pkg::WORD_ZERO;
      if (addr_phase && !hwrite) begin
         unique case (rd_offs)
            port_mux_pkg::OFFS_DIRECTION:
               rdata_next[7:0] = dir_next;
            port_mux_pkg::OFFS_OUT_LATCH:
               rdata_next[7:0] = latch_next;
            port_mux_pkg::OFFS_IN_SAMPLE:
               rdata_next[7:0] = sample_reg;
            port_mux_pkg::OFFS_CONTROL:
               rdata_next[port_mux_pkg::CTRL_W-1:0] = ctrl_next;
            port_mux_pkg::OFFS_PCHG_SRC:
               rdata_next[7:0] = pchg_next;
            port_mux_pkg::OFFS_DIGIN_OFF:
               rdata_next[7:0] = digoff_next;
            port_mux_pkg::OFFS_PAD_STATUS: begin
               rdata_next[port_mux_pkg::STAT_OE_LSB +: 8]     = oe_reg;
               rdata_next[port_mux_pkg::STAT_PULLUP_LSB +: 8] = pull_reg;
               rdata_next[port_mux_pkg::STAT_DIN_EN_LSB +: 8] = din_en_reg;
            end
            default:
               rdata_next = port_mux_pkg::WORD_ZERO;   // unmapped reads zero
         endcase
      end
   end

   // read data holds through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= port_mux_pkg::WORD_ZERO;
      end else if (addr_phase) begin
         rdata_reg <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hrdata            = rdata_reg;
   assign hreadyout         = 1'b1;                       // never stalls
   assign hresp             = port_mux_pkg::RESP_OKAY;    // always okay
   assign pad_out           = out_reg;
   assign pad_oe            = oe_reg;
   assign pad_pullup_en     = pull_reg;
   assign pad_digital_in_en = din_en_reg;

   // hsize is accepted but only whole words are expected
   wire logic unused_bus = ^{hsize, haddr[31:8], hwdata[31:8]};

endmodule : port_pin_override_mux
